/* verilog/mode_register_pkg.sv */
package mode_register_pkg;

    // ********************************************
    // Mode addresses
    // ********************************************
    localparam logic [7:0] ADDR_LATENCY = 8'h02;
    localparam logic [7:0] ADDR_DRIVE = 8'h03;
    localparam logic [7:0] ADDR_TEMPERATURE = 8'h04;
    localparam logic [7:0] ADDR_MAKER = 8'h05;
    localparam logic [7:0] ADDR_DIE_REVISION = 8'h06;
    localparam logic [7:0] ADDR_SECOND_REVISION = 8'h07;
    localparam logic [7:0] ADDR_INFO = 8'h08;

    // ********************************************
    // Field positions
    // ********************************************
    localparam int CODE_LSB = 0;
    localparam int CODE_MSB = 3;
    localparam int RATE_LSB = 0;
    localparam int RATE_MSB = 2;
    localparam int HOT_BIT = 2;
    localparam int UPDATE_FLAG_BIT = 7;
    localparam int TYPE_LSB = 0;
    localparam int DENSITY_LSB = 2;
    localparam int WIDTH_LSB = 6;

    // ********************************************
    // Reset values
    // ********************************************
    localparam logic [3:0] LATENCY_RESET = 4'h1;
    localparam logic [3:0] DRIVE_RESET = 4'h2;
    localparam logic UPDATE_FLAG_RESET = 1'b0;
    localparam logic [7:0] READ_IDLE_DATA = 8'h00;

    // ********************************************
    // Latency codes
    // ********************************************
    localparam logic [3:0] LAT_3_1 = 4'h1;
    localparam logic [3:0] LAT_4_2 = 4'h2;
    localparam logic [3:0] LAT_5_2 = 4'h3;
    localparam logic [3:0] LAT_6_3 = 4'h4;
    localparam logic [3:0] LAT_7_4 = 4'h5;
    localparam logic [3:0] LAT_8_4 = 4'h6;

    // ********************************************
    // Drive impedance codes
    // ********************************************
    localparam logic [3:0] DRV_34_OHM = 4'h1;
    localparam logic [3:0] DRV_40_OHM = 4'h2;
    localparam logic [3:0] DRV_48_OHM = 4'h3;
    localparam logic [3:0] DRV_60_OHM = 4'h4;
    localparam logic [3:0] DRV_80_OHM = 4'h6;
    localparam logic [3:0] DRV_120_OHM = 4'h7;

    // ********************************************
    // Refresh-rate codes
    // ********************************************
    localparam logic [2:0] RATE_TOO_COLD = 3'h0;
    localparam logic [2:0] RATE_4X = 3'h1;
    localparam logic [2:0] RATE_2X = 3'h2;
    localparam logic [2:0] RATE_1X = 3'h3;
    localparam logic [2:0] RATE_RESERVED = 3'h4;
    localparam logic [2:0] RATE_QUARTER = 3'h5;
    localparam logic [2:0] RATE_QUARTER_DERATE = 3'h6;
    localparam logic [2:0] RATE_TOO_HOT = 3'h7;
    localparam logic [2:0] RATE_RESET = 3'h3;

    // ********************************************
    // Carriers
    // ********************************************
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] mode_address;
        logic [7:0] mode_operand_bits;
    } mode_request_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } mode_answer_t;

    typedef struct packed {
        logic [3:0] read_latency;
        logic [2:0] write_latency;
    } latency_pair_t;

endpackage : mode_register_pkg

/* verilog/refresh_rate_tracker.sv */
`timescale 1ns/1ps
module refresh_rate_tracker (
    input wire logic clk, // 25 MHz clock
    input wire logic rst_b, // Synchronous reset
    input wire logic [2:0] sensor_rate, // Rate code from the sensor
    input wire logic read_clear, // Temperature register read
    output logic [2:0] rate, // Reported rate field
    output logic temperature_update_flag // Field changed since last read
);

    wire logic changed = (sensor_rate != rate);
    wire logic next_flag = changed | (temperature_update_flag & ~read_clear);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rate <= mode_register_pkg::RATE_RESET;
            temperature_update_flag <= mode_register_pkg::UPDATE_FLAG_RESET;
        end else begin
            rate <= sensor_rate;
            // A change in the same cycle as the read keeps the flag set.
            temperature_update_flag <= next_flag;
        end
    end

    a_flag_on_change: assert property (@(posedge clk) disable iff (!rst_b)
        changed |=> temperature_update_flag)
        else $error("update flag not set after rate change");

    a_flag_read_clear: assert property (@(posedge clk) disable iff (!rst_b)
        read_clear && !changed |=> !temperature_update_flag)
        else $error("update flag not cleared by read");

    a_flag_holds: assert property (@(posedge clk) disable iff (!rst_b)
        temperature_update_flag && !read_clear |=> temperature_update_flag)
        else $error("update flag lost without a read");

endmodule : refresh_rate_tracker

/* verilog/mode_register_bank.sv */
// Behaviour
// - Latency register 02h write-only; code 1..6 picks read/write latency pair.
// - Drive register 03h write-only; codes 1,2,3,4,6,7 select impedance.
// - Temperature register 04h read-only: rate in bits 2:0, flag bit 7.
// - Rate codes: cold, 4x, 2x, 1x, reserved, quarter, derated quarter, hot.
// - Reading the temperature register clears the update flag, unless the rate changes in that same cycle.
// - Update flag is zero after power-up.
// - Rate bit 2 high means temperature above 85 degrees Celsius.
// - Codes 000b and 111b are out-of-range temperature conditions.
// - Address 05h returns one fixed eight-bit maker code.
// - Address 06h returns a fixed die revision code.
// - Address 07h returns a fixed secondary revision code.
// - Address 08h: type bits 1:0, density bits 5:2, width bits 7:6.
`timescale 1ns/1ps
module mode_register_bank #(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] DIE_REVISION_CODE = 8'h3c, // Arbitrary value
    parameter logic [7:0] SECOND_REVISION_CODE = 8'h7e, // Arbitrary value
    parameter logic [1:0] DEVICE_TYPE = 2'h0, // Four-bit prefetch
    parameter logic [3:0] DENSITY_CODE = 4'h7, // Density code
    parameter logic [1:0] IO_WIDTH_CODE = 2'h0 // I/O width code
) (
    input wire logic clk, // 25 MHz clock
    input wire logic rst_b, // Synchronous reset, active low
    input mode_register_pkg::mode_request_t request, // Mode register command
    input wire logic [2:0] sensor_rate, // Rate code from the sensor
    output mode_register_pkg::mode_answer_t answer, // Read answer
    output logic [3:0] latency_code, // Stored latency code
    output mode_register_pkg::latency_pair_t latency, // Decoded latencies
    output logic [3:0] output_drive_impedance, // Stored drive code
    output logic over_85c, // Temperature above 85 C
    output logic out_of_range, // Temperature outside limits
    output logic derate_timing // Controller must derate timings
);

    // ********************************************
    // Decoding functions
    // ********************************************
    function automatic logic latency_legal(input logic [3:0] code);
        latency_legal = (code >= mode_register_pkg::LAT_3_1) &&
                        (code <= mode_register_pkg::LAT_8_4);
    endfunction : latency_legal

    function automatic mode_register_pkg::latency_pair_t latency_of(input logic [3:0] code);
        latency_of = '{read_latency: 4'h3, write_latency: 3'h1};
        unique case (code)
            mode_register_pkg::LAT_4_2: latency_of = '{read_latency: 4'h4, write_latency: 3'h2};
            mode_register_pkg::LAT_5_2: latency_of = '{read_latency: 4'h5, write_latency: 3'h2};
            mode_register_pkg::LAT_6_3: latency_of = '{read_latency: 4'h6, write_latency: 3'h3};
            mode_register_pkg::LAT_7_4: latency_of = '{read_latency: 4'h7, write_latency: 3'h4};
            mode_register_pkg::LAT_8_4: latency_of = '{read_latency: 4'h8, write_latency: 3'h4};
            default: latency_of = '{read_latency: 4'h3, write_latency: 3'h1};
        endcase
    endfunction : latency_of

    function automatic logic drive_legal(input logic [3:0] code);
        drive_legal = (code >= mode_register_pkg::DRV_34_OHM) &&
                      (code <= mode_register_pkg::DRV_120_OHM) &&
                      (code != 4'h5);
    endfunction : drive_legal

    // ********************************************
    // Command decode
    // ********************************************
    wire logic [3:0] operand_code =
        request.mode_operand_bits[mode_register_pkg::CODE_MSB:mode_register_pkg::CODE_LSB];
    wire logic write_latency_reg = request.write && !request.read &&
        (request.mode_address == mode_register_pkg::ADDR_LATENCY);
    wire logic write_drive_reg = request.write && !request.read &&
        (request.mode_address == mode_register_pkg::ADDR_DRIVE);
    wire logic read_request = request.read && !request.write;
    wire logic read_temperature = read_request &&
        (request.mode_address == mode_register_pkg::ADDR_TEMPERATURE);
    wire logic take_latency = write_latency_reg && latency_legal(operand_code);
    wire logic take_drive = write_drive_reg && drive_legal(operand_code);

    // ********************************************
    // Temperature tracking
    // ********************************************
    logic [2:0] rate;
    logic temperature_update_flag;

    refresh_rate_tracker tracker (
        .clk(clk),
        .rst_b(rst_b),
        .sensor_rate(sensor_rate),
        .read_clear(read_temperature),
        .rate(rate),
        .temperature_update_flag(temperature_update_flag)
    );

    wire logic [7:0] temperature_word = {temperature_update_flag, 4'h0, rate};
    wire logic [7:0] info_word = {IO_WIDTH_CODE, DENSITY_CODE, DEVICE_TYPE};
    wire logic rate_hot = rate[mode_register_pkg::HOT_BIT];
    wire logic rate_outside = (rate == mode_register_pkg::RATE_TOO_COLD) ||
                              (rate == mode_register_pkg::RATE_TOO_HOT);
    wire logic rate_derate = (rate == mode_register_pkg::RATE_QUARTER_DERATE);

    // ********************************************
    // Read data selection
    // ********************************************
    logic [7:0] read_word;

    always_comb begin
        unique case (request.mode_address)
            mode_register_pkg::ADDR_TEMPERATURE: read_word = temperature_word;
            mode_register_pkg::ADDR_MAKER: read_word = MAKER_CODE;
            mode_register_pkg::ADDR_DIE_REVISION: read_word = DIE_REVISION_CODE;
            mode_register_pkg::ADDR_SECOND_REVISION: read_word = SECOND_REVISION_CODE;
            mode_register_pkg::ADDR_INFO: read_word = info_word;
            default: read_word = mode_register_pkg::READ_IDLE_DATA;
        endcase
    end

    wire logic [7:0] next_data = read_request ? read_word : mode_register_pkg::READ_IDLE_DATA;

    // ********************************************
    // Registers
    // ********************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            latency_code <= mode_register_pkg::LATENCY_RESET;
            latency <= latency_of(mode_register_pkg::LATENCY_RESET);
        end else if (take_latency) begin
            latency_code <= operand_code;
            latency <= latency_of(operand_code);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            output_drive_impedance <= mode_register_pkg::DRIVE_RESET;
        end else if (take_drive) begin
            output_drive_impedance <= operand_code;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            answer <= '{valid: 1'b0, data: mode_register_pkg::READ_IDLE_DATA};
        end else begin
            answer <= '{valid: read_request, data: next_data};
        end
    end

    // Status follows the reported field one cycle later.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            over_85c <= 1'b0;
            out_of_range <= 1'b0;
            derate_timing <= 1'b0;
        end else begin
            over_85c <= rate_hot;
            out_of_range <= rate_outside;
            derate_timing <= rate_derate;
        end
    end

    // ********************************************
    // Assertions
    // ********************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_latency_write: assert property (
        take_latency |=> latency_code == $past(operand_code) &&
            latency == latency_of($past(operand_code)))
        else $error("latency code not stored");

    a_latency_reserved: assert property (
        write_latency_reg && !latency_legal(operand_code) |=> $stable(latency_code))
        else $error("reserved latency code accepted");

    a_latency_pair: assert property (
        latency_code == mode_register_pkg::LAT_6_3 |-> latency.read_latency == 4'h6 &&
            latency.write_latency == 3'h3)
        else $error("latency pair mismatch");

    a_drive_write: assert property (
        write_drive_reg && operand_code == 4'h5 |=> $stable(output_drive_impedance))
        else $error("reserved drive code accepted");

    a_drive_update: assert property (
        take_drive |=> output_drive_impedance == $past(operand_code))
        else $error("drive code not stored");

    a_temp_read_data: assert property (
        read_temperature |=> answer.valid &&
            answer.data == {$past(temperature_update_flag), 4'h0, $past(rate)})
        else $error("temperature read data wrong");

    a_temp_flag_clear: assert property (
        read_temperature ##1 (rate == $past(rate)) |-> !temperature_update_flag)
        else $error("read did not clear update flag");

    a_hot_status: assert property (
        ##1 over_85c == $past(rate[mode_register_pkg::HOT_BIT]))
        else $error("over 85 status wrong");

    a_range_status: assert property (
        rate == mode_register_pkg::RATE_TOO_HOT |=> out_of_range && over_85c)
        else $error("out of range not reported");

    a_maker_read: assert property (
        read_request && request.mode_address == mode_register_pkg::ADDR_MAKER
            |=> answer.data == MAKER_CODE)
        else $error("maker code wrong");

    a_info_read: assert property (
        read_request && request.mode_address == mode_register_pkg::ADDR_INFO
            |=> answer.data[1:0] == DEVICE_TYPE && answer.data[7:6] == IO_WIDTH_CODE)
        else $error("info register wrong");

    a_density_read: assert property (
        read_request && request.mode_address == mode_register_pkg::ADDR_INFO
            |=> answer.data[5:2] == DENSITY_CODE)
        else $error("density field wrong");

    a_die_rev_read: assert property (
        read_request && request.mode_address == mode_register_pkg::ADDR_DIE_REVISION
            |=> answer.data == DIE_REVISION_CODE)
        else $error("die revision wrong");

    a_second_rev_read: assert property (
        read_request && request.mode_address == mode_register_pkg::ADDR_SECOND_REVISION
            |=> answer.data == SECOND_REVISION_CODE)
        else $error("secondary revision wrong");

    a_derate_status: assert property (
        ##1 derate_timing == ($past(rate) == mode_register_pkg::RATE_QUARTER_DERATE))
        else $error("derate status wrong");

    a_cold_status: assert property (
        rate == mode_register_pkg::RATE_TOO_COLD |=> out_of_range && !over_85c)
        else $error("cold limit not reported");

    a_flag_after_reset: assert property (
        $rose(rst_b) |-> !temperature_update_flag)
        else $error("update flag set after reset");

    a_answer_idle: assert property (
        !read_request |=> !answer.valid && answer.data == 8'h00)
        else $error("spurious read answer");

endmodule : mode_register_bank

/* dv/mode_controller_model.sv */
`timescale 1ns/1ps
// ********************************************
// Controller side of the mode register bus
// ********************************************
module mode_controller_model (
    input wire logic clk, // Bus clock
    output mode_register_pkg::mode_request_t request // Mode register command
);
    initial begin
        request = '0;
    end

    // Drives one command from the next falling edge until the next call; reserved codes only when the caller asks.
    task issue(input logic wr, input logic rd, input logic [7:0] addr, input logic [7:0] op);
        @(negedge clk);
        request <= '{write: wr, read: rd, mode_address: addr, mode_operand_bits: op};
    endtask : issue

    // Released fields show the inverse of their last value, so stale data cannot pass.
    task idle();
        @(negedge clk);
        request <= '{write: 1'b0, read: 1'b0, mode_address: ~request.mode_address,
                     mode_operand_bits: ~request.mode_operand_bits};
    endtask : idle

    // Derating adds 1.875 ns to each core row timing.
    function automatic int derated_delay_ps(input int base_ps, input logic derate);
        return derate ? base_ps + 1875 : base_ps;
    endfunction : derated_delay_ps
endmodule : mode_controller_model

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] MAKER = 8'ha5; // Arbitrary value
    localparam logic [7:0] DIE_REV = 8'h96; // Arbitrary value
    localparam logic [7:0] SECOND_REV = 8'h69; // Arbitrary value
    localparam logic [1:0] DEV_TYPE = 2'h1;
    localparam logic [3:0] DENSITY = 4'h7;
    localparam logic [1:0] IO_WIDTH = 2'h1;
    localparam int LIMIT = 2000;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] sensor_rate = 3'h3;
    mode_register_pkg::mode_request_t request;
    mode_register_pkg::mode_answer_t answer;
    mode_register_pkg::latency_pair_t latency;
    logic [3:0] latency_code;
    logic [3:0] drive;
    logic over_85c;
    logic out_of_range;
    logic derate_timing;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int seed = 32'h5883;
    logic [7:0] exp_q[$];
    int due_q[$];
    logic [3:0] cur_lat = 4'h1;
    logic [3:0] cur_drv = 4'h2;
    logic [7:0] r8;

    always #20 clk = ~clk;

    mode_register_bank #(.MAKER_CODE(MAKER), .DIE_REVISION_CODE(DIE_REV),
        .SECOND_REVISION_CODE(SECOND_REV), .DEVICE_TYPE(DEV_TYPE), .DENSITY_CODE(DENSITY),
        .IO_WIDTH_CODE(IO_WIDTH)) i_dut (
        .clk(clk), .rst_b(rst_b), .request(request), .sensor_rate(sensor_rate),
        .answer(answer), .latency_code(latency_code), .latency(latency),
        .output_drive_impedance(drive), .over_85c(over_85c), .out_of_range(out_of_range),
        .derate_timing(derate_timing));

    mode_controller_model i_ctrl (.clk(clk), .request(request));

    // ********************************************
    // Checking
    // ********************************************
    task give_verdict();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic [7:0] pair_of(input logic [3:0] code);
        case (code)
            4'h1: return 8'h31;
            4'h2: return 8'h42;
            4'h3: return 8'h52;
            4'h4: return 8'h63;
            4'h5: return 8'h74;
            default: return 8'h84;
        endcase
    endfunction : pair_of

    task check_cfg();
        check({4'h0, latency_code}, {4'h0, cur_lat});
        check({latency.read_latency, 1'b0, latency.write_latency}, pair_of(cur_lat));
        check({4'h0, drive}, {4'h0, cur_drv});
    endtask : check_cfg

    task rd(input logic [7:0] addr, input logic [7:0] exp);
        i_ctrl.issue(1'b0, 1'b1, addr, 8'h00);
        exp_q.push_back(exp);
        due_q.push_back(cyc + 1);
    endtask : rd

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc >= LIMIT) begin
            num_errors = num_errors + 1;
            give_verdict();
        end
    end

    // Every answer is matched against the oldest pending read, in value and in cycle.
    always @(negedge clk) begin
        if (answer.valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, answer.data, 8'h00);
            end else begin
                check(answer.data, exp_q.pop_front());
                check(8'(cyc), 8'(due_q.pop_front()));
            end
        end
    end

    // ********************************************
    // Stimulus
    // ********************************************
    initial begin
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        check_cfg();
        rd(mode_register_pkg::ADDR_TEMPERATURE, 8'h03);
        rd(8'h05, MAKER);
        rd(8'h06, DIE_REV);
        rd(8'h07, SECOND_REV);
        rd(8'h08, {IO_WIDTH, DENSITY, DEV_TYPE});
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h09, 8'h00);
        for (int c = 0; c < 16; c++) begin
            r8 = 8'($random(seed));
            i_ctrl.issue(1'b1, 1'b0, 8'h02, {r8[7:4], c[3:0]});
            if (c >= 1 && c <= 6) cur_lat = c[3:0];
            i_ctrl.issue(1'b1, 1'b0, 8'h03, {r8[3:0], c[3:0]});
            if (c inside {1, 2, 3, 4, 6, 7}) cur_drv = c[3:0];
            i_ctrl.idle();
            check_cfg();
        end
        i_ctrl.issue(1'b1, 1'b1, 8'h02, 8'h01);
        i_ctrl.issue(1'b1, 1'b0, 8'h04, 8'h80);
        i_ctrl.idle();
        check_cfg();
        for (int c = 0; c < 8; c++) begin
            sensor_rate = c[2:0];
            repeat (3) @(negedge clk);
            check({7'h0, over_85c}, {7'h0, c[2]});
            check({7'h0, out_of_range}, {7'h0, c == 0 || c == 7});
            check({7'h0, derate_timing}, {7'h0, c == 6});
            check(8'(i_ctrl.derated_delay_ps(0, derate_timing) / 125),
                (c == 6) ? 8'h0f : 8'h00);
            rd(8'h04, {1'b1, 4'h0, c[2:0]});
            i_ctrl.idle();
        end
        rd(8'h04, 8'h07);
        i_ctrl.idle();
        r8 = 8'($random(seed));
        sensor_rate = (r8[2:0] == 3'h7) ? 3'h5 : r8[2:0];
        repeat (3) @(negedge clk);
        sensor_rate = 3'h7;
        repeat (3) @(negedge clk);
        rd(8'h04, 8'h87);
        rd(8'h04, 8'h07);
        i_ctrl.idle();
        repeat (4) @(negedge clk);
        check(8'(exp_q.size()), 8'h00);
        give_verdict();
    end
endmodule : testbench
